// [rtl/adcr_defines.vh]
// Constants and state codes for the selected-mode serial readout block.
`ifndef ADCR_DEFINES_VH
`define ADCR_DEFINES_VH

// Device clock period in nanoseconds (250 MHz).
`define ADCR_CLK_PERIOD_NS 4
// Result width in bits.
`define ADCR_DATA_BITS 16
// Conversion time window in nanoseconds; plain defaults.
`define ADCR_TCONV_MIN_NS 500
`define ADCR_TCONV_MAX_NS 2200
// Least time rounds up, longest time rounds down.
`define ADCR_CONV_MIN_CYC ((`ADCR_TCONV_MIN_NS + `ADCR_CLK_PERIOD_NS - 1) / `ADCR_CLK_PERIOD_NS)
`define ADCR_CONV_MAX_CYC (`ADCR_TCONV_MAX_NS / `ADCR_CLK_PERIOD_NS)
// Conversion counter width.
`define ADCR_CNT_BITS 12
// Shift counts: plain read, and read behind a start bit.
`define ADCR_SHIFTS_PLAIN 5'h10
`define ADCR_SHIFTS_BUSY 5'h11
// Main state codes.
`define ADCR_ST_IDLE 2'h0
`define ADCR_ST_CONV 2'h1
`define ADCR_ST_WAIT 2'h2
`define ADCR_ST_READ 2'h3

`endif

// [rtl/adcr_sync.v]
// Two flip-flop synchroniser for one asynchronous pin level.
module adcr_sync (
    // Clock and reset.
    input wire clk,
    input wire srst,
    // Asynchronous level in, synchronised level out.
    input wire async_in,
    output reg sync_out
);

    // First stage; only the second stage reads it.
    reg meta;

    // ********************************************************
    // Two-stage capture
    // ********************************************************
    // Both stages clear on reset so the edge finders start quiet.
    always @(posedge clk) begin
        if (srst) begin
            meta <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule // adcr_sync

// [rtl/adcr_edge.v]
// Edge finder on a synchronised level, with its one-cycle delayed copy.
module adcr_edge (
    // Clock and reset.
    input wire clk,
    input wire srst,
    // Synchronised level.
    input wire level,
    // Level one cycle earlier, and edge pulses.
    output reg level_d,
    output wire rise,
    output wire fall
);

    // Counts the first cycles after reset, while the synchroniser still
    // fills with the pin level; a change seen then is only that filling.
    reg [1:0] settle;

    // ********************************************************
    // Delay stage
    // ********************************************************
    // The delayed copy is also handed out so callers can see the level
    // that stood just before an edge.
    always @(posedge clk) begin
        if (srst) begin
            level_d <= 1'b0;
            settle <= 2'h0;
        end else begin
            level_d <= level;
            if (settle != 2'h3) begin
                settle <= settle + 2'h1;
            end
        end
    end

    // One-cycle pulses on each transition, quiet until the fill is over,
    // so a pin that idles high gives no false edge after reset.
    assign rise = level & ~level_d & (settle == 2'h3);
    assign fall = ~level & level_d & (settle == 2'h3);

endmodule // adcr_edge

// [rtl/adcr_readout.v]
// Conversion control and selected-mode serial readout of a 16-bit converter.
`include "adcr_defines.vh"

module adcr_readout #(
    // Conversion length in device clock cycles.
    parameter [11:0] CONV_CYCLES = `ADCR_CONV_MAX_CYC
) (
    // Clock and reset.
    input wire clk,
    input wire srst,
    // Pins from the host, asynchronous to clk.
    input wire conversion_trigger,
    input wire serial_select_input,
    input wire serial_clock,
    // Result of the analog core, valid at conversion end.
    input wire [15:0] conv_result,
    // Serial result pin as output and enable.
    output reg serial_result_output,
    output reg serial_result_output_oe,
    // Status for the surrounding core.
    output reg converting,
    output reg powered_down,
    output reg chain_mode,
    output reg start_bit_enabled
);

    // ********************************************************
    // Pin synchronisers and edge finders
    // ********************************************************

    // Synchronised pin levels.
    wire trig_s;
    wire sel_s;
    wire sck_s;
    // Delayed copies and edge pulses.
    wire trig_d;
    wire sel_d;
    wire trig_rise;
    wire sck_fall;
    // The edge finders stay quiet for the first cycles after reset, while
    // the synchronisers fill with the pin levels; a trigger pin that already
    // stands high at release is therefore never taken for a new conversion.

    adcr_sync u_sync_trig (
        .clk(clk),
        .srst(srst),
        .async_in(conversion_trigger),
        .sync_out(trig_s)
    );

    adcr_sync u_sync_sel (
        .clk(clk),
        .srst(srst),
        .async_in(serial_select_input),
        .sync_out(sel_s)
    );

    adcr_sync u_sync_sck (
        .clk(clk),
        .srst(srst),
        .async_in(serial_clock),
        .sync_out(sck_s)
    );

    adcr_edge u_edge_trig (
        .clk(clk),
        .srst(srst),
        .level(trig_s),
        .level_d(trig_d),
        .rise(trig_rise),
        .fall()
    );

    adcr_edge u_edge_sel (
        .clk(clk),
        .srst(srst),
        .level(sel_s),
        .level_d(sel_d),
        .rise(),
        .fall()
    );

    adcr_edge u_edge_sck (
        .clk(clk),
        .srst(srst),
        .level(sck_s),
        .level_d(),
        .rise(),
        .fall(sck_fall)
    );

    // ********************************************************
    // Select decoding
    // ********************************************************

    // The part is deselected only while both trigger and select are high.
    // In 3-wire use the select pin stays high and the trigger selects; in
    // 4-wire use the trigger stays high and the select pin selects.
    wire deselected;
    wire deselected_d;
    wire select_fall;
    wire deselect_rise;

    assign deselected = trig_s & sel_s;
    assign deselected_d = trig_d & sel_d;
    // Selection begins: trigger fall in 3-wire, select fall in 4-wire.
    assign select_fall = deselected_d & ~deselected;
    // Selection ends: trigger rise in 3-wire, select rise in 4-wire.
    assign deselect_rise = deselected & ~deselected_d;
    // In 3-wire use the trigger rise is also a new conversion and wins; in
    // 4-wire use a select rise alone only floats the line for the next part.

    // The mode choice uses the select level from the cycle before the
    // trigger edge, so a select pin wired to the trigger reads low there.
    wire sel_at_edge;
    assign sel_at_edge = sel_d;

    // ********************************************************
    // State and datapath registers
    // ********************************************************

    // Main state.
    reg [1:0] state;
    reg [1:0] next_state;
    // Conversion cycle counter.
    reg [11:0] conv_cnt;
    // Result shift register; its top bit is the bit on the pin.
    reg [15:0] shreg;
    // Falling clock edges still to come before the pin floats.
    reg [4:0] shifts_left;
    // Start bit currently on the pin, ahead of the MSB.
    reg start_phase;
    // Conversion end, decoded from the counter.
    wire conv_done;

    assign conv_done = (state == `ADCR_ST_CONV) && (conv_cnt == CONV_CYCLES - 12'h001);

    // ********************************************************
    // Next-state logic
    // ********************************************************
    // A trigger rise restarts from every state but CONV, because a
    // new conversion always aborts a readout in progress.
    always @* begin
        next_state = state;
        case (state)
            `ADCR_ST_IDLE: begin
                if (trig_rise) begin
                    next_state = `ADCR_ST_CONV;
                end
            end
            `ADCR_ST_CONV: begin
                // The trigger is not looked at until the count ends.
                if (conv_done) begin
                    if (chain_mode) begin
                        next_state = `ADCR_ST_IDLE;
                    end else if (!trig_s || !sel_s) begin
                        next_state = `ADCR_ST_READ;
                    end else begin
                        next_state = `ADCR_ST_WAIT;
                    end
                end
            end
            `ADCR_ST_WAIT: begin
                // The result waits here until the host selects the part.
                if (trig_rise) begin
                    next_state = `ADCR_ST_CONV;
                end else if (select_fall) begin
                    next_state = `ADCR_ST_READ;
                end
            end
            `ADCR_ST_READ: begin
                if (trig_rise) begin
                    next_state = `ADCR_ST_CONV;
                end else if (deselect_rise) begin
                    next_state = `ADCR_ST_IDLE;
                end else if (sck_fall && shifts_left == 5'h01) begin
                    next_state = `ADCR_ST_IDLE;
                end
            end
            default: begin
                next_state = `ADCR_ST_IDLE;
            end
        endcase
    end

    // ********************************************************
    // State register and conversion control
    // ********************************************************
    // The counter only runs inside a conversion; mode and start-bit flags
    // are fixed at the trigger edge (chain) or at conversion end (selected).
    always @(posedge clk) begin
        if (srst) begin
            state <= `ADCR_ST_IDLE;
            conv_cnt <= 12'h000;
            chain_mode <= 1'b0;
            start_bit_enabled <= 1'b0;
        end else begin
            state <= next_state;
            if (trig_rise && (state != `ADCR_ST_CONV)) begin
                conv_cnt <= 12'h000;
                chain_mode <= ~sel_at_edge;
                // Chain mode decides its start bit from the clock level.
                start_bit_enabled <= ~sel_at_edge & sck_s;
            end else if (state == `ADCR_ST_CONV) begin
                conv_cnt <= conv_cnt + 12'h001;
                if (conv_done && !chain_mode) begin
                    start_bit_enabled <= ~trig_s | ~sel_s;
                end
            end
        end
    end

    // ********************************************************
    // Shift register and bit counting
    // ********************************************************
    // Bits move only on falling serial clock edges, so each bit stands
    // from one falling edge to the next and spans the rising edge between.
    // Count and start flag are reloaded at every conversion end, so a
    // readout cut short leaves nothing stale for the next one.
    always @(posedge clk) begin
        if (srst) begin
            shreg <= 16'h0000;
            shifts_left <= 5'h00;
            start_phase <= 1'b0;
        end else if (conv_done) begin
            shreg <= conv_result;
            if (!trig_s || !sel_s) begin
                // Low start bit first, then sixteen data bits.
                shifts_left <= `ADCR_SHIFTS_BUSY;
                start_phase <= 1'b1;
            end else begin
                shifts_left <= `ADCR_SHIFTS_PLAIN;
                start_phase <= 1'b0;
            end
        end else if (state == `ADCR_ST_READ && sck_fall && shifts_left != 5'h00) begin
            shifts_left <= shifts_left - 5'h01;
            if (start_phase) begin
                // The first fall after the start bit brings up the MSB.
                start_phase <= 1'b0;
            end else begin
                shreg <= {shreg[14:0], 1'b0};
            end
        end
    end

    // ********************************************************
    // Serial result pin
    // ********************************************************
    // The pin is registered so it never glitches between states. The
    // output floats through a conversion, whatever the trigger does, so
    // a pull-up can hold it high until the start bit pulls it low.
    always @(posedge clk) begin
        if (srst) begin
            serial_result_output <= 1'b0;
            serial_result_output_oe <= 1'b0;
        end else begin
            case (next_state)
                `ADCR_ST_CONV: begin
                    serial_result_output <= 1'b0;
                    serial_result_output_oe <= 1'b0;
                end
                `ADCR_ST_READ: begin
                    if (conv_done || (start_phase && !sck_fall)) begin
                        serial_result_output <= 1'b0;
                    end else if (state == `ADCR_ST_READ && sck_fall && !start_phase) begin
                        serial_result_output <= shreg[14];
                    end else if (state == `ADCR_ST_READ && sck_fall) begin
                        // The fall that ends the start bit shows the MSB at once.
                        serial_result_output <= shreg[15];
                    end else begin
                        serial_result_output <= shreg[15];
                    end
                    serial_result_output_oe <= 1'b1;
                end
                `ADCR_ST_IDLE: begin
                    // With nothing to read, the line is driven low only while trigger and select are both low.
                    serial_result_output <= 1'b0;
                    serial_result_output_oe <= ~trig_s & ~sel_s;
                end
                default: begin
                    serial_result_output <= 1'b0;
                    serial_result_output_oe <= 1'b0;
                end
            endcase
        end
    end

    // ********************************************************
    // Status outputs
    // ********************************************************
    // The core powers down as soon as a conversion ends and stays in the
    // acquisition phase until the next trigger; no host action is needed.
    // Both levels are registered from the next state, so they change in
    // the same cycle as the state and never glitch.
    always @(posedge clk) begin
        if (srst) begin
            converting <= 1'b0;
            powered_down <= 1'b1;
        end else begin
            converting <= (next_state == `ADCR_ST_CONV);
            powered_down <= (next_state != `ADCR_ST_CONV);
        end
    end

endmodule // adcr_readout

// [dv/adcr_properties.sv]
// Concurrent checks on the readout block's pins and status.
module adcr_properties #(
    parameter [11:0] CONV_CYCLES = 12'h226
) (
    // Clock and reset.
    input wire clk,
    input wire srst,
    // Host pins.
    input wire conversion_trigger,
    input wire serial_select_input,
    input wire serial_clock,
    // Result pin and status.
    input wire serial_result_output,
    input wire serial_result_output_oe,
    input wire converting,
    input wire powered_down,
    input wire chain_mode,
    input wire start_bit_enabled
);
    timeunit 1ns;
    timeprecision 1ps;
    // Conversion cycles, serial clock falls while driving, last clock level.
    logic [11:0] cnt;
    logic [4:0] falls;
    logic sck_q;
    // Counts restart when their condition drops, so no stale count leaks.
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt <= 12'h0;
            falls <= 5'h0;
            sck_q <= 1'b0;
        end else begin
            cnt <= converting ? cnt + 12'h1 : 12'h0;
            falls <= serial_result_output_oe ? falls + {4'h0, sck_q & ~serial_clock} : 5'h0;
            sck_q <= serial_clock;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_len;
        $fell(converting) |-> cnt == CONV_CYCLES;
    endproperty
    a_len: assert property (p_len)
        else $error("bad conversion length");
    property p_quiet;
        converting |-> !serial_result_output_oe && !powered_down;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("output or power wrong while converting");
    property p_pd;
        $fell(converting) |-> powered_down;
    endproperty
    a_pd: assert property (p_pd)
        else $error("no power down after conversion");
    property p_cs;
        $rose(conversion_trigger) && $past(serial_select_input) && !converting
            |-> ##[3:5] converting && !chain_mode;
    endproperty
    a_cs: assert property (p_cs)
        else $error("selected mode not entered");
    property p_chain;
        $rose(conversion_trigger) && !$past(serial_select_input) && !converting
            |-> ##[3:5] converting && chain_mode && start_bit_enabled == serial_clock;
    endproperty
    a_chain: assert property (p_chain)
        else $error("chain mode or its start bit wrong");
    property p_start;
        $fell(converting) ##1 start_bit_enabled && !chain_mode
            |-> ##[0:2] serial_result_output_oe && !serial_result_output;
    endproperty
    a_start: assert property (p_start)
        else $error("start bit not driven low");
    property p_hold;
        serial_clock && $past(serial_clock) && serial_result_output_oe
            && $past(serial_result_output_oe) |-> $stable(serial_result_output);
    endproperty
    a_hold: assert property (p_hold)
        else $error("bit changed while serial clock high");
    property p_shifts;
        serial_result_output_oe |-> falls <= (start_bit_enabled ? 5'h11 : 5'h10);
    endproperty
    a_shifts: assert property (p_shifts)
        else $error("driven past the last bit");
    c_busy: cover property ($fell(converting) ##1 start_bit_enabled);
    c_chain: cover property (converting && chain_mode);
    c_full: cover property (falls == 5'h11);
endmodule // adcr_properties

bind adcr_readout adcr_properties #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
    .clk(clk), .srst(srst), .conversion_trigger(conversion_trigger),
    .serial_select_input(serial_select_input), .serial_clock(serial_clock),
    .serial_result_output(serial_result_output),
    .serial_result_output_oe(serial_result_output_oe), .converting(converting),
    .powered_down(powered_down), .chain_mode(chain_mode),
    .start_bit_enabled(start_bit_enabled));

// [dv/adcr_host_model.sv]
// Host model: drives trigger, select and serial clock, reads the result line.
module adcr_host_model (
    // Clock used to align level changes.
    input wire clk,
    // Result pin from the converter.
    input wire dout,
    input wire dout_oe,
    // Pins towards the converter.
    output logic trig,
    output logic sel,
    output logic sck
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up on the line: a floating output reads high.
    // One converter alone sits on this line, so no two parts drive it.
    wire line = dout_oe ? dout : 1'b1;
    // Serial clock stands low outside frames.
    initial begin
        trig = 1'b0;
        sel = 1'b1;
        sck = 1'b0;
    end
    // Sets all three pin levels just after a clock edge.
    task pins(input logic t, input logic s, input logic k);
        @(posedge clk);
        trig <= t;
        sel <= s;
        sck <= k;
    endtask
    // Frame of n clock pulses at 125 ns, capturing on each rising edge.
    task read(input int n, output logic [16:0] v);
        v = 17'h0;
        #62.5;
        repeat (n) begin
            sck = 1'b1;
            v = {v[15:0], line};
            #62.5;
            sck = 1'b0;
            #62.5;
        end
    endtask
endmodule // adcr_host_model

// [dv/tb_adc_serial_readout_select_mode.sv]
// Self-checking bench for the selected-mode serial readout block.
module tb_adc_serial_readout_select_mode;
    timeunit 1ns;
    timeprecision 1ps;
    // Short conversion keeps the run brief.
    localparam logic [11:0] CONV = 12'h014;
    // One case: four-wire or three-wire, start bit or not, result.
    typedef struct packed {logic four; logic busy; logic [15:0] d;} adcr_row_t;
    // Result LSBs are zero, so an early float shows as a wrong last bit.
    adcr_row_t rows [4] = '{'{1'b0, 1'b0, 16'ha5c2}, '{1'b0, 1'b1, 16'h8000},
        '{1'b1, 1'b0, 16'h7ffe}, '{1'b1, 1'b1, 16'h3c5a}};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] res = 16'h0;
    logic [16:0] v;
    int fails = 0;
    int n_compared = 0;
    wire trig, sel, sck, dout, oe, conv, pd, chain, sbe;
    always #2 clk = ~clk;
    adcr_readout #(.CONV_CYCLES(CONV)) dut (.clk(clk), .srst(srst),
        .conversion_trigger(trig), .serial_select_input(sel), .serial_clock(sck),
        .conv_result(res), .serial_result_output(dout), .serial_result_output_oe(oe),
        .converting(conv), .powered_down(pd), .chain_mode(chain), .start_bit_enabled(sbe));
    adcr_host_model host (.clk(clk), .dout(dout), .dout_oe(oe), .trig(trig), .sel(sel),
        .sck(sck));
    // Counts a comparison and reports a mismatch at once.
    task check(input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Waits for the conversion to end; a hang counts as a mismatch.
    task wait_done;
        int i;
        i = 0;
        repeat (8) @(posedge clk);
        while (conv !== 1'b0 && i < 200) begin
            @(posedge clk);
            i++;
        end
        if (i == 200) begin
            fails++;
            end_of_test();
        end
        repeat (4) @(posedge clk);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        check({oe, dout, conv, pd, chain, sbe}, 17'h04);
        srst <= 1'b0;
        // Ordinary cases: the start bit comes from selecting the part before the conversion ends.
        foreach (rows[i]) begin
            res <= rows[i].d;
            host.pins(1'b0, 1'b1, 1'b0);
            host.pins(1'b1, 1'b1, 1'b0);
            repeat (8) @(posedge clk);
            check({conv, oe, chain}, 17'h4);
            if (rows[i].busy) begin
                host.pins(rows[i].four, !rows[i].four, 1'b0);
            end
            wait_done;
            check({sbe, oe, pd}, {14'h0, rows[i].busy, rows[i].busy, 1'b1});
            host.pins(rows[i].four, !rows[i].four, 1'b0);
            host.read(rows[i].busy ? 17 : 16, v);
            check(v, {1'b0, rows[i].d});
            repeat (10) @(posedge clk);
            check(oe, 1'b0);
        end
        // Trigger glitch inside the conversion is ignored.
        host.pins(1'b0, 1'b1, 1'b0);
        host.pins(1'b1, 1'b1, 1'b0);
        repeat (6) @(posedge clk);
        host.pins(1'b0, 1'b1, 1'b0);
        repeat (4) @(posedge clk);
        host.pins(1'b1, 1'b1, 1'b0);
        repeat (3) @(posedge clk);
        check(conv, 1'b1);
        wait_done;
        check(sbe, 1'b0);
        // Readout cut short by a trigger rise, which also restarts.
        host.pins(1'b0, 1'b1, 1'b0);
        host.read(5, v);
        check(v, {12'h0, res[15:11]});
        host.pins(1'b1, 1'b1, 1'b0);
        repeat (8) @(posedge clk);
        check({oe, conv}, 17'h1);
        wait_done;
        host.pins(1'b0, 1'b1, 1'b0);
        host.read(16, v);
        check(v, {1'b0, res});
        // Four-wire readout cut short by the select rising.
        host.pins(1'b1, 1'b1, 1'b0);
        wait_done;
        host.pins(1'b1, 1'b0, 1'b0);
        host.read(3, v);
        check(v, {14'h0, res[15:13]});
        host.pins(1'b1, 1'b1, 1'b0);
        repeat (8) @(posedge clk);
        check({oe, conv}, 17'h0);
        // Both pins low drive the line low; tied pins pick chain mode.
        host.pins(1'b0, 1'b0, 1'b0);
        repeat (8) @(posedge clk);
        check({oe, dout}, 17'h2);
        host.pins(1'b1, 1'b1, 1'b0);
        repeat (8) @(posedge clk);
        check({conv, chain, sbe}, 17'h6);
        wait_done;
        host.pins(1'b0, 1'b0, 1'b1);
        host.pins(1'b1, 1'b0, 1'b1);
        repeat (8) @(posedge clk);
        check({conv, chain, sbe}, 17'h7);
        wait_done;
        // Reset in mid-conversion, released with the trigger pin high.
        host.pins(1'b0, 1'b1, 1'b0);
        host.pins(1'b1, 1'b1, 1'b0);
        repeat (8) @(posedge clk);
        srst <= 1'b1;
        repeat (5) @(posedge clk);
        check({oe, dout, conv, pd, chain, sbe}, 17'h04);
        srst <= 1'b0;
        repeat (10) @(posedge clk);
        check({oe, dout, conv, pd, chain, sbe}, 17'h04);
        end_of_test();
    end
endmodule // tb_adc_serial_readout_select_mode
